/* verilog/dsd_top.sv */
// Status flag detection and output terminal routing for a motor drive.
`timescale 1ns/1ps
`default_nettype none
module dsd_top #(
	parameter int TICK_CYCLES = dsd_pkg::TICK_CYCLES_DEF
) (
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire logic [15:0] i_out_freq_raw,
	input wire logic [15:0] i_set_freq,
	input wire logic i_reverse,
	input wire logic [7:0] i_out_current_pct,
	input wire logic i_running,
	input wire logic i_dc_brake,
	input wire logic i_trip_valid,
	input wire logic [7:0] i_trip_code,
	input wire logic i_ground_fault_cause,
	input wire logic [6:0] i_up_to_freq_sensitivity,
	input wire logic [15:0] i_forward_freq_threshold,
	input wire logic [15:0] i_reverse_freq_threshold,
	input wire logic [7:0] i_overcurrent_level,
	input wire logic [6:0] i_overcurrent_delay,
	input wire logic [7:0] i_zero_current_level,
	input wire logic [6:0] i_zero_current_time,
	input wire logic [9:0] i_term0_sel,
	input wire logic [9:0] i_term1_sel,
	input wire logic [9:0] i_term2_sel,
	output logic o_power_off_fault_flag,
	output logic o_up_to_freq_flag,
	output logic o_freq_threshold_flag,
	output logic o_overcurrent_flag,
	output logic o_zero_current_flag,
	output logic o_term0,
	output logic o_term1,
	output logic o_term2
);

	////////////////////////////////////////////////////////////////////////
	// Selector decode, shared by all terminals.
	function automatic logic term_level(input logic [9:0] sel, input logic [4:0] f);
		logic r;
		r = 1'b0;
		case (sel)
			dsd_pkg::SEL_POF_POS: r = f[0];
			dsd_pkg::SEL_POF_NEG: r = ~f[0];
			dsd_pkg::SEL_UP_POS: r = f[1];
			dsd_pkg::SEL_UP_NEG: r = ~f[1];
			dsd_pkg::SEL_THR_POS: r = f[2];
			dsd_pkg::SEL_THR_NEG: r = ~f[2];
			dsd_pkg::SEL_OC_POS: r = f[3];
			dsd_pkg::SEL_OC_NEG: r = ~f[3];
			dsd_pkg::SEL_ZC_POS: r = f[4];
			dsd_pkg::SEL_ZC_NEG: r = ~f[4];
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Millisecond tick for the delay and hold timers.
	logic [31:0] div_q;
	logic tick_q;

	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			div_q <= 32'h0;
			tick_q <= 1'b0;
		end
		else if (div_q >= 32'(TICK_CYCLES - 1))
		begin
			div_q <= 32'h0;
			tick_q <= 1'b1;
		end
		else
		begin
			div_q <= div_q + 32'h1;
			tick_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Fault class flag.
	logic pof_d;

	always_comb
	begin
		pof_d = 1'b0;
		// trip classes that mean a drive or wiring failure.
		case (i_trip_code)
			dsd_pkg::TRIP_BRAKE, dsd_pkg::TRIP_GROUND, dsd_pkg::TRIP_PHASE,
			dsd_pkg::TRIP_PSTORE, dsd_pkg::TRIP_BOARD, dsd_pkg::TRIP_CPU6,
			dsd_pkg::TRIP_CPU7, dsd_pkg::TRIP_CPU, dsd_pkg::TRIP_INRUSH: pof_d = 1'b1;
			// ground fault shown as acceleration overcurrent.
			dsd_pkg::TRIP_ACCEL_OC: pof_d = i_ground_fault_cause;
			default: pof_d = 1'b0;
		endcase
		pof_d = pof_d & i_trip_valid;
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			o_power_off_fault_flag <= 1'b0;
		else
			o_power_off_fault_flag <= pof_d;
	end

	////////////////////////////////////////////////////////////////////////
	// Frequency flags. The raw input is the frequency before slip compensation.
	logic [15:0] fdiff;
	logic [15:0] thr;
	logic up_d;

	always_comb
	begin
		// raw frequency used for both compares.
		fdiff = (i_out_freq_raw >= i_set_freq) ? i_out_freq_raw - i_set_freq : i_set_freq - i_out_freq_raw;
		// band is sensitivity percent of set frequency.
		up_d = (24'(fdiff) * 24'h64) <= (24'(i_set_freq) * 24'(i_up_to_freq_sensitivity));
		thr = (i_reverse && i_reverse_freq_threshold != dsd_pkg::REV_SAME_AS_FWD) ?
			i_reverse_freq_threshold : i_forward_freq_threshold;
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_up_to_freq_flag <= 1'b0;
			o_freq_threshold_flag <= 1'b0;
		end
		// DC braking forces both flags off.
		else if (i_dc_brake)
		begin
			o_up_to_freq_flag <= 1'b0;
			o_freq_threshold_flag <= 1'b0;
		end
		else
		begin
			o_up_to_freq_flag <= up_d;
			o_freq_threshold_flag <= i_out_freq_raw >= thr;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Current flags. Timers saturate, so a 10 s delay never wraps.
	logic oc_cond;
	logic zc_cond;
	logic [13:0] oc_lim;
	logic [13:0] zc_lim;
	logic [13:0] oc_cnt_q;
	logic [13:0] zc_cnt_q;
	logic [13:0] oc_hold_q;
	logic [13:0] zc_hold_q;

	always_comb
	begin
		// level compared as percent of rated current.
		oc_cond = i_running && (i_out_current_pct >= i_overcurrent_level);
		// zero-current level in percent of rated.
		zc_cond = i_running && (i_zero_current_level != 8'h00) && (i_out_current_pct < i_zero_current_level);
		oc_lim = 14'(i_overcurrent_delay) * dsd_pkg::OC_STEP_TICKS;
		zc_lim = 14'(i_zero_current_time) * dsd_pkg::ZC_STEP_TICKS;
	end

	// delay timers restart when the condition drops.
	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			oc_cnt_q <= 14'h0;
			zc_cnt_q <= 14'h0;
		end
		else
		begin
			if (!oc_cond)
				oc_cnt_q <= 14'h0;
			else if (tick_q && oc_cnt_q != 14'h3FFF)
				oc_cnt_q <= oc_cnt_q + 14'h1;
			if (!zc_cond)
				zc_cnt_q <= 14'h0;
			else if (tick_q && zc_cnt_q != 14'h3FFF)
				zc_cnt_q <= zc_cnt_q + 14'h1;
		end
	end

	// flag held after the condition ends.
	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_overcurrent_flag <= 1'b0;
			oc_hold_q <= 14'h0;
		end
		else if (oc_cond && oc_cnt_q >= oc_lim)
		begin
			o_overcurrent_flag <= 1'b1;
			oc_hold_q <= dsd_pkg::HOLD_TICKS;
		end
		else if (oc_hold_q != 14'h0)
			oc_hold_q <= oc_hold_q - 14'(tick_q);
		else
			o_overcurrent_flag <= 1'b0;
	end

	// zero-current flag after the detection time.
	// flag held after the condition ends.
	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_zero_current_flag <= 1'b0;
			zc_hold_q <= 14'h0;
		end
		else if (zc_cond && zc_cnt_q >= zc_lim)
		begin
			o_zero_current_flag <= 1'b1;
			zc_hold_q <= dsd_pkg::HOLD_TICKS;
		end
		else if (zc_hold_q != 14'h0)
			zc_hold_q <= zc_hold_q - 14'(tick_q);
		else
			o_zero_current_flag <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Terminal routing. Driving from the flag registers costs one cycle
	// but keeps each terminal a clean flop output.
	logic [4:0] flags;
	logic [9:0] sel [3];
	logic [2:0] term_q;

	assign flags = {o_zero_current_flag, o_overcurrent_flag, o_freq_threshold_flag,
		o_up_to_freq_flag, o_power_off_fault_flag};
	assign sel[0] = i_term0_sel;
	assign sel[1] = i_term1_sel;
	assign sel[2] = i_term2_sel;

	for (genvar t = 0; t < 3; t++)
	begin : g_term
		always_ff @(posedge i_ref_clk or negedge i_arst_n)
		begin
			if (!i_arst_n)
				term_q[t] <= 1'b0;
			else
				term_q[t] <= term_level(sel[t], flags);
		end
	end

	assign o_term0 = term_q[0];
	assign o_term1 = term_q[1];
	assign o_term2 = term_q[2];

	////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_arst_n);

	dcb_blocks_a: assert property (i_dc_brake |=> !o_up_to_freq_flag && !o_freq_threshold_flag)
		else $error("Frequency flag set during DC braking.");
	fwd_thr_a: assert property (!i_dc_brake && !i_reverse && i_out_freq_raw >= i_forward_freq_threshold
		|=> o_freq_threshold_flag)
		else $error("Forward threshold flag missing.");
	rev_thr_a: assert property (!i_dc_brake && i_reverse && i_reverse_freq_threshold != dsd_pkg::REV_SAME_AS_FWD
		&& i_out_freq_raw < i_reverse_freq_threshold |=> !o_freq_threshold_flag)
		else $error("Reverse threshold ignored.");
	up_exact_a: assert property (!i_dc_brake && i_out_freq_raw == i_set_freq |=> o_up_to_freq_flag)
		else $error("Up-to-frequency missing at set frequency.");
	pof_trip_a: assert property (i_trip_valid && i_trip_code == dsd_pkg::TRIP_BRAKE |=> o_power_off_fault_flag)
		else $error("Fault flag missing for brake trip.");
	gnd_accel_a: assert property (i_trip_valid && i_trip_code == dsd_pkg::TRIP_ACCEL_OC && i_ground_fault_cause
		|=> o_power_off_fault_flag)
		else $error("Fault flag missing for ground fault.");
	pof_clear_a: assert property (!i_trip_valid |=> !o_power_off_fault_flag)
		else $error("Fault flag without trip.");
	zc_off_a: assert property (i_zero_current_level == 8'h00 && !o_zero_current_flag
		|=> !o_zero_current_flag)
		else $error("Zero-current flag with detection off.");
	oc_stop_a: assert property (!i_running && !o_overcurrent_flag |=> !o_overcurrent_flag)
		else $error("Overcurrent flag while stopped.");
	oc_hold_a: assert property ($rose(o_overcurrent_flag) |-> o_overcurrent_flag[*8])
		else $error("Overcurrent flag not held.");
	zc_hold_a: assert property ($rose(o_zero_current_flag) |-> o_zero_current_flag[*8])
		else $error("Zero-current flag not held.");
	term_pos_a: assert property (i_term0_sel == dsd_pkg::SEL_OC_POS |=> o_term0 == $past(o_overcurrent_flag))
		else $error("Terminal 0 positive routing wrong.");
	term_neg_a: assert property (i_term1_sel == dsd_pkg::SEL_UP_NEG |=> o_term1 == !$past(o_up_to_freq_flag))
		else $error("Terminal 1 negative routing wrong.");

	oc_seen_c: cover property ($rose(o_overcurrent_flag));
	zc_seen_c: cover property ($rose(o_zero_current_flag));
	rev_seen_c: cover property (i_reverse && o_freq_threshold_flag);
	pof_seen_c: cover property ($rose(o_power_off_fault_flag));

endmodule
`default_nettype wire

/* verilog/dsd_pkg.sv */
// Constants shared by the drive status signal detector.
`default_nettype none
package dsd_pkg;
	localparam int CLK_HZ = 50_000_000;
	// Timer tick period in microseconds, and the cycles it takes.
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES_DEF = CLK_HZ / 1_000_000 * TICK_US;
	// Hold time of the current flags in milliseconds, and in ticks.
	localparam int HOLD_MS = 100;
	localparam logic [13:0] HOLD_TICKS = 14'(HOLD_MS * 1000 / TICK_US);
	// Ticks per setting step: overcurrent delay in 0.1 s, zero-current time in 0.01 s.
	localparam logic [13:0] OC_STEP_TICKS = 14'(100_000 / TICK_US);
	localparam logic [13:0] ZC_STEP_TICKS = 14'(10_000 / TICK_US);
	// Reverse threshold value meaning use the forward threshold.
	localparam logic [15:0] REV_SAME_AS_FWD = 16'h270F;
	// Power-on defaults of the settings, for the integrator.
	localparam logic [6:0] SENS_DEF = 7'h0A;
	localparam logic [15:0] FWD_THR_DEF = 16'h003C;
	localparam logic [7:0] OC_LEVEL_DEF = 8'h96;
	localparam logic [6:0] OC_DELAY_DEF = 7'h00;
	localparam logic [7:0] ZC_LEVEL_DEF = 8'h05;
	localparam logic [6:0] ZC_TIME_DEF = 7'h32;
	// Terminal selector codes.
	localparam logic [9:0] SEL_UP_POS = 10'h001;
	localparam logic [9:0] SEL_UP_NEG = 10'h065;
	localparam logic [9:0] SEL_THR_POS = 10'h004;
	localparam logic [9:0] SEL_THR_NEG = 10'h068;
	localparam logic [9:0] SEL_OC_POS = 10'h00C;
	localparam logic [9:0] SEL_OC_NEG = 10'h070;
	localparam logic [9:0] SEL_ZC_POS = 10'h00D;
	localparam logic [9:0] SEL_ZC_NEG = 10'h071;
	localparam logic [9:0] SEL_POF_POS = 10'h05B;
	localparam logic [9:0] SEL_POF_NEG = 10'h0BF;
	// Trip codes reported by the control core; the values are arbitrary.
	localparam logic [7:0] TRIP_BRAKE = 8'h01;
	localparam logic [7:0] TRIP_GROUND = 8'h02;
	localparam logic [7:0] TRIP_PHASE = 8'h03;
	localparam logic [7:0] TRIP_PSTORE = 8'h04;
	localparam logic [7:0] TRIP_BOARD = 8'h05;
	localparam logic [7:0] TRIP_CPU6 = 8'h06;
	localparam logic [7:0] TRIP_CPU7 = 8'h07;
	localparam logic [7:0] TRIP_CPU = 8'h08;
	localparam logic [7:0] TRIP_INRUSH = 8'h09;
	localparam logic [7:0] TRIP_ACCEL_OC = 8'h0A;
endpackage
`default_nettype wire

/* verification/dsd_term_reader.sv */
// Model of the external equipment that reads the drive's output terminals.
`timescale 1ns/1ps
`default_nettype none
module dsd_term_reader (
	input wire logic i_ref_clk,
	input wire logic [2:0] i_terms,
	output logic [2:0] o_seen
);
	// The equipment latches the contacts on its own edge, so it sees them one cycle late.
	always_ff @(posedge i_ref_clk)
	begin
		o_seen <= i_terms;
	end
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking testbench for the drive status signal detector.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic i_ref_clk = 1'b0;
	logic i_arst_n = 1'b0;
	logic [15:0] ofreq = 16'h0000;
	logic [15:0] setf = 16'h0258;
	logic rev = 1'b0;
	logic [7:0] cur = 8'h00;
	logic run = 1'b0;
	logic dcb = 1'b0;
	logic tv = 1'b0;
	logic [7:0] tcode = 8'h00;
	logic gnd = 1'b0;
	logic [6:0] sens = dsd_pkg::SENS_DEF;
	logic [15:0] fthr = dsd_pkg::FWD_THR_DEF;
	logic [15:0] rthr = dsd_pkg::REV_SAME_AS_FWD;
	logic [7:0] ocl = dsd_pkg::OC_LEVEL_DEF;
	logic [6:0] ocd = dsd_pkg::OC_DELAY_DEF;
	logic [7:0] zcl = 8'h00;
	logic [6:0] zct = 7'h01;
	logic [9:0] s0 = 10'h000;
	logic [9:0] s1 = 10'h000;
	logic [9:0] s2 = 10'h000;
	logic pof, up, thr, oc, zc;
	wire logic [2:0] t;
	logic [2:0] seen;
	int mismatches = 0;
	int num_checks = 0;
	int cycles = 0;
	// A short tick keeps the 100 ms hold at 400 cycles.
	dsd_top #(.TICK_CYCLES(4)) i_dut (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_out_freq_raw(ofreq),
		.i_set_freq(setf), .i_reverse(rev), .i_out_current_pct(cur), .i_running(run), .i_dc_brake(dcb),
		.i_trip_valid(tv), .i_trip_code(tcode), .i_ground_fault_cause(gnd),
		.i_up_to_freq_sensitivity(sens), .i_forward_freq_threshold(fthr),
		.i_reverse_freq_threshold(rthr), .i_overcurrent_level(ocl), .i_overcurrent_delay(ocd),
		.i_zero_current_level(zcl), .i_zero_current_time(zct), .i_term0_sel(s0), .i_term1_sel(s1),
		.i_term2_sel(s2), .o_power_off_fault_flag(pof), .o_up_to_freq_flag(up), .o_freq_threshold_flag(thr),
		.o_overcurrent_flag(oc), .o_zero_current_flag(zc), .o_term0(t[0]), .o_term1(t[1]), .o_term2(t[2]));
	dsd_term_reader i_reader (.i_ref_clk(i_ref_clk), .i_terms(t), .o_seen(seen));
	always #10 i_ref_clk = ~i_ref_clk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// A hung run would otherwise never reach the verdict.
	always @(posedge i_ref_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			wrap_up();
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask
	task automatic chk(input logic got, input logic exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_fault();
		logic [7:0] codes [9];
		codes = '{dsd_pkg::TRIP_BRAKE, dsd_pkg::TRIP_GROUND, dsd_pkg::TRIP_PHASE, dsd_pkg::TRIP_PSTORE,
			dsd_pkg::TRIP_BOARD, dsd_pkg::TRIP_CPU6, dsd_pkg::TRIP_CPU7, dsd_pkg::TRIP_CPU, dsd_pkg::TRIP_INRUSH};
		@(posedge i_ref_clk);
		s0 <= dsd_pkg::SEL_POF_POS;
		s1 <= dsd_pkg::SEL_POF_NEG;
		tv <= 1'b1;
		foreach (codes[k])
		begin
			@(posedge i_ref_clk);
			tcode <= codes[k];
			cyc(4);
			chk(pof, 1'b1);
			chk(seen[0], 1'b1);
			chk(seen[1], 1'b0);
			chk(seen[2], 1'b0);
		end
		@(posedge i_ref_clk);
		tcode <= dsd_pkg::TRIP_ACCEL_OC;
		cyc(4);
		chk(pof, 1'b0);
		@(posedge i_ref_clk);
		gnd <= 1'b1;
		cyc(4);
		chk(pof, 1'b1);
		@(posedge i_ref_clk);
		tv <= 1'b0;
		cyc(4);
		chk(pof, 1'b0);
		chk(seen[1], 1'b1);
	endtask
	task automatic fq(input logic [15:0] f, input logic r, input logic [15:0] rt, input logic b,
		input logic eu, input logic et);
		@(posedge i_ref_clk);
		ofreq <= f;
		rev <= r;
		rthr <= rt;
		dcb <= b;
		cyc(4);
		chk(up, eu);
		chk(thr, et);
		chk(seen[0], eu);
		chk(seen[1], ~et);
		chk(seen[2], et);
	endtask
	task automatic t_freq();
		@(posedge i_ref_clk);
		s0 <= dsd_pkg::SEL_UP_POS;
		s1 <= dsd_pkg::SEL_THR_NEG;
		s2 <= dsd_pkg::SEL_THR_POS;
		fq(16'h0294, 1'b0, 16'h270F, 1'b0, 1'b1, 1'b1);
		fq(16'h0295, 1'b0, 16'h270F, 1'b0, 1'b0, 1'b1);
		fq(16'h021C, 1'b0, 16'h270F, 1'b0, 1'b1, 1'b1);
		fq(16'h021B, 1'b0, 16'h270F, 1'b0, 1'b0, 1'b1);
		fq(16'h003B, 1'b0, 16'h270F, 1'b0, 1'b0, 1'b0);
		fq(16'h003C, 1'b1, 16'h270F, 1'b0, 1'b0, 1'b1);
		fq(16'h003C, 1'b1, 16'h0064, 1'b0, 1'b0, 1'b0);
		fq(16'h0064, 1'b1, 16'h0064, 1'b0, 1'b0, 1'b1);
		fq(16'h003C, 1'b0, 16'h0064, 1'b0, 1'b0, 1'b1);
		fq(16'h0258, 1'b0, 16'h270F, 1'b1, 1'b0, 1'b0);
	endtask
	// Sensitivity end points, with the negative up-to-frequency and overcurrent codes.
	task automatic t_sens();
		@(posedge i_ref_clk);
		s1 <= dsd_pkg::SEL_UP_NEG;
		s2 <= dsd_pkg::SEL_OC_NEG;
		dcb <= 1'b0;
		sens <= 7'h00;
		ofreq <= setf;
		cyc(4);
		chk(up, 1'b1);
		chk(seen[1], 1'b0);
		chk(seen[2], 1'b1);
		@(posedge i_ref_clk);
		ofreq <= setf + 16'h0001;
		cyc(4);
		chk(up, 1'b0);
		chk(seen[1], 1'b1);
		@(posedge i_ref_clk);
		sens <= 7'h64;
		ofreq <= 16'h0000;
		cyc(4);
		chk(up, 1'b1);
		@(posedge i_ref_clk);
		ofreq <= 16'h04B1;
		cyc(4);
		chk(up, 1'b0);
		@(posedge i_ref_clk);
		sens <= dsd_pkg::SENS_DEF;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_cur();
		@(posedge i_ref_clk);
		s0 <= dsd_pkg::SEL_OC_POS;
		s1 <= dsd_pkg::SEL_ZC_NEG;
		s2 <= dsd_pkg::SEL_ZC_POS;
		cur <= 8'h02;
		run <= 1'b1;
		cyc(100);
		chk(zc, 1'b0);
		chk(seen[1], 1'b1);
		@(posedge i_ref_clk);
		zcl <= dsd_pkg::ZC_LEVEL_DEF;
		cyc(20);
		chk(zc, 1'b0);
		cyc(40);
		chk(zc, 1'b1);
		chk(seen[1], 1'b0);
		chk(seen[2], 1'b1);
		@(posedge i_ref_clk);
		cur <= 8'h95;
		cyc(300);
		chk(zc, 1'b1);
		chk(oc, 1'b0);
		cyc(200);
		chk(zc, 1'b0);
		@(posedge i_ref_clk);
		cur <= 8'h96;
		cyc(4);
		chk(oc, 1'b1);
		chk(seen[0], 1'b1);
		@(posedge i_ref_clk);
		cur <= 8'h64;
		cyc(300);
		chk(oc, 1'b1);
		cyc(200);
		chk(oc, 1'b0);
		@(posedge i_ref_clk);
		run <= 1'b0;
		cur <= 8'hC8;
		cyc(50);
		chk(oc, 1'b0);
		@(posedge i_ref_clk);
		run <= 1'b1;
		ocd <= 7'h01;
		cyc(300);
		chk(oc, 1'b0);
		@(posedge i_ref_clk);
		cur <= 8'h64;
		@(posedge i_ref_clk);
		cur <= 8'hC8;
		cyc(300);
		chk(oc, 1'b0);
		cyc(150);
		chk(oc, 1'b1);
	endtask
	initial
	begin
		repeat (8) @(posedge i_ref_clk);
		i_arst_n <= 1'b1;
		cyc(2);
		t_fault();
		t_freq();
		t_sens();
		t_cur();
		wrap_up();
	end
endmodule
`default_nettype wire
